// ---- design/eom_top.v ----
`include "eom_defs.vh"
module eom_top (
   input  wire        CLK,
   input  wire        RST,
   input  wire [3:0]  ADDR,
   input  wire [15:0] WDATA,
   input  wire        WR,
   input  wire        RD,
   output reg  [15:0] RDATA,
   input  wire [7:0]  DIN,
   input  wire [13:0] TRIPS_IN,
   input  wire        RUN_CMD,
   input  wire        REF_VALID,
   input  wire [15:0] REF_SPEED,
   input  wire        SAFE_TORQUE_OFF_N,
   output reg         OVERRIDE_ACTIVE,
   output reg         RUN_OUT,
   output reg  [15:0] SPEED_OUT,
   output reg         TRIP_OUT,
   output reg  [13:0] TRIPS_OUT,
   output reg         IRQ
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [15:0] ctrl_r;
   reg  [15:0] override_speed_setpoint_r;
   reg  [2:0]  irq_stat_r;
   reg  [2:0]  irq_mask_r;
   reg         act_d_r;
   wire        enabled;
   wire        act;
   wire        tripped;
   wire        restart;
   wire [13:0] eff;

   eom_src_sel u_sel (
      .mode     (ctrl_r[4:0]),
      .src_sel  (ctrl_r[10:8]),
      .din      (DIN),
      .polarity (ctrl_r[`EOM_CTRL_POL_BIT]),
      .enabled  (enabled),
      .active   (act)
   );

   // suppressed trips vanish while active; restored when inactive
   assign eff = act ? (TRIPS_IN & ~`EOM_SUPPRESS_MASK) : TRIPS_IN;

   eom_restart u_rst (
      .clk       (CLK),
      .rst       (RST),
      .fault     (act & |(TRIPS_IN & `EOM_RESTART_MASK)),
      .tripped_r (tripped),
      .restart_r (restart)
   );

   // ----------------------------------------------------------------
   // bus, status and interrupts
   // ----------------------------------------------------------------
   wire [2:0] ev = {restart, ~act & act_d_r, act & ~act_d_r};

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctrl_r                    <= `EOM_CTRL_RESET;
         override_speed_setpoint_r <= 16'h0000;
         irq_stat_r                <= 3'h0;
         irq_mask_r                <= 3'h0;
         act_d_r                   <= 1'b0;
         RDATA                     <= 16'h0000;
         IRQ                       <= 1'b0;
      end else begin
         act_d_r <= act;
         if (WR && ADDR == `EOM_ADDR_CTRL)
            ctrl_r <= WDATA;
         if (WR && ADDR == `EOM_ADDR_SPEED)
            override_speed_setpoint_r <= WDATA;
         if (WR && ADDR == `EOM_ADDR_MASK)
            irq_mask_r <= WDATA[2:0];
         // set wins over write-one-to-clear
         if (WR && ADDR == `EOM_ADDR_IRQ)
            irq_stat_r <= (irq_stat_r & ~WDATA[2:0]) | ev;
         else
            irq_stat_r <= irq_stat_r | ev;
         IRQ <= |(irq_stat_r & irq_mask_r);
         RDATA <= 16'h0000;
         if (RD) begin
            case (ADDR)
               `EOM_ADDR_CTRL:   RDATA <= ctrl_r;
               `EOM_ADDR_SPEED:  RDATA <= override_speed_setpoint_r;
               `EOM_ADDR_STATUS: RDATA <= {13'h0000, tripped, act, enabled};
               `EOM_ADDR_IRQ:    RDATA <= {13'h0000, irq_stat_r};
               `EOM_ADDR_MASK:   RDATA <= {13'h0000, irq_mask_r};
               `EOM_ADDR_TRIPS:  RDATA <= {2'h0, eff};
               default:          RDATA <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // command path
   // ----------------------------------------------------------------
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         OVERRIDE_ACTIVE <= 1'b0;
         RUN_OUT         <= 1'b0;
         SPEED_OUT       <= 16'h0000;
         TRIP_OUT        <= 1'b0;
         TRIPS_OUT       <= 14'h0000;
      end else begin
         OVERRIDE_ACTIVE <= act;
         TRIPS_OUT       <= eff;
         // restart faults stay latched-off only while the drive recovers
         TRIP_OUT <= act ? tripped : |eff;
         if (!SAFE_TORQUE_OFF_N) begin
            RUN_OUT   <= 1'b0;
            SPEED_OUT <= 16'h0000;
         end else if (act && override_speed_setpoint_r != 16'h0000) begin
            RUN_OUT   <= ~tripped;
            SPEED_OUT <= override_speed_setpoint_r;
         end else if (act) begin
            RUN_OUT   <= RUN_CMD & REF_VALID & ~tripped;
            SPEED_OUT <= REF_SPEED;
         end else begin
            RUN_OUT   <= RUN_CMD & REF_VALID & ~|eff;
            SPEED_OUT <= REF_SPEED;
         end
      end
   end
endmodule

// ---- design/eom_defs.vh ----
`ifndef EOM_DEFS_VH
`define EOM_DEFS_VH
// What this block does
// - override active on closure if normally open, on opening if closed
// - control mode 4, 8 or 13 enables override from digital input 2
// - control mode 0 takes override from user source selection
// - while active, suppress thermal, external, signal, phase, comms, overload
// - while active, voltage, current, output faults trip, auto reset, restart
// - override speed zero keeps normal source; run and reference needed
// - nonzero override speed runs fixed speed, ignores all but torque off and restart trips
// - while active the drive keeps running until physically unable

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EOM_ADDR_CTRL    4'h0
`define EOM_ADDR_SPEED   4'h1
`define EOM_ADDR_STATUS  4'h2
`define EOM_ADDR_IRQ     4'h3
`define EOM_ADDR_MASK    4'h4
`define EOM_ADDR_TRIPS   4'h5

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define EOM_CTRL_MODE_LSB   0
`define EOM_CTRL_POL_BIT    5
`define EOM_CTRL_SRC_LSB    8
`define EOM_CTRL_RESET      16'h0000
`define EOM_MODE_USER       5'h00
`define EOM_MODE_A          5'h04
`define EOM_MODE_B          5'h08
`define EOM_MODE_C          5'h0D

// ----------------------------------------------------------------
// trip vector layout
// ----------------------------------------------------------------
`define EOM_NTRIP           14
`define EOM_SUPPRESS_MASK   14'h01FF
`define EOM_RESTART_MASK    14'h3E00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EOM_CLK_MHZ         25
`define EOM_RESTART_US      100
`define EOM_RESTART_CYC     (`EOM_RESTART_US * `EOM_CLK_MHZ)
`endif

// ---- design/eom_src_sel.v ----
`include "eom_defs.vh"
module eom_src_sel (
   input  wire [4:0] mode,
   input  wire [2:0] src_sel,
   input  wire [7:0] din,
   input  wire       polarity,
   output reg        enabled,
   output reg        active
);
   reg lvl;
   always @* begin
      enabled = 1'b0;
      lvl     = 1'b0;
      if (mode == `EOM_MODE_A || mode == `EOM_MODE_B ||
          mode == `EOM_MODE_C) begin
         enabled = 1'b1;
         lvl     = din[1];
      end else if (mode == `EOM_MODE_USER) begin
         enabled = 1'b1;
         lvl     = din[src_sel];
      end
      // polarity 0: closure activates; 1: opening activates
      active = enabled & (polarity ? ~lvl : lvl);
   end
endmodule

// ---- design/eom_restart.v ----
`include "eom_defs.vh"
module eom_restart (
   input  wire clk,
   input  wire rst,
   input  wire fault,
   output reg  tripped_r,
   output reg  restart_r
);
   reg [15:0] cnt_r;
   // hold off until the fault clears, then count a settle time
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tripped_r <= 1'b0;
         restart_r <= 1'b0;
         cnt_r     <= 16'h0000;
      end else begin
         restart_r <= 1'b0;
         if (fault) begin
            tripped_r <= 1'b1;
            cnt_r     <= 16'h0000;
         end else if (tripped_r) begin
            if (cnt_r == `EOM_RESTART_CYC - 1) begin
               tripped_r <= 1'b0;
               restart_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
      end
   end
endmodule

// ---- verification/eom_chk.sv ----
module eom_chk (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic [13:0] TRIPS_IN,
   input wire logic        RUN_CMD,
   input wire logic        REF_VALID,
   input wire logic        SAFE_TORQUE_OFF_N,
   input wire logic        OVERRIDE_ACTIVE,
   input wire logic        RUN_OUT,
   input wire logic [15:0] SPEED_OUT,
   input wire logic        TRIP_OUT,
   input wire logic [13:0] TRIPS_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_sto; !SAFE_TORQUE_OFF_N |=> !RUN_OUT && SPEED_OUT == 16'h0000;
   endproperty
   a_sto: assert property (p_sto) else $error("run while torque off");
   property p_mask; OVERRIDE_ACTIVE && $past(OVERRIDE_ACTIVE)
      |-> (TRIPS_OUT & 14'h01FF) == 14'h0000; endproperty
   a_mask: assert property (p_mask) else $error("trip not masked");
   property p_quiet; OVERRIDE_ACTIVE[*3] ##0 !$past(TRIP_OUT)
      && $past(TRIPS_IN[13:9]) == 5'h00 && $past(TRIPS_IN[13:9], 2) == 5'h00
      |-> !TRIP_OUT; endproperty
   a_quiet: assert property (p_quiet) else $error("masked trip fired");
   property p_hard; OVERRIDE_ACTIVE[*2] ##0 TRIPS_IN[13:9] != 5'h00
      |-> ##[1:2] TRIP_OUT; endproperty
   a_hard: assert property (p_hard) else $error("no hard trip");
   property p_keep; RUN_OUT && OVERRIDE_ACTIVE && RUN_CMD && REF_VALID
      && SAFE_TORQUE_OFF_N && TRIPS_IN == 14'h0000
      |=> RUN_OUT || !OVERRIDE_ACTIVE; endproperty
   a_keep: assert property (p_keep) else $error("override run dropped");
   // override may come back in the same cycle: only judge calm stretches
   property p_norm; !OVERRIDE_ACTIVE[*2] ##0 TRIPS_IN[0] ##1 !OVERRIDE_ACTIVE
      |-> TRIP_OUT; endproperty
   a_norm: assert property (p_norm) else $error("protection lost");
   property p_cmd; !OVERRIDE_ACTIVE[*2] ##0 !RUN_CMD ##1 !OVERRIDE_ACTIVE
      |-> !RUN_OUT; endproperty
   a_cmd: assert property (p_cmd) else $error("run without command");
   property p_ref; OVERRIDE_ACTIVE[*2] ##0 RUN_CMD && !REF_VALID
      && SAFE_TORQUE_OFF_N ##1 RUN_OUT |-> SPEED_OUT != 16'h0000; endproperty
   a_ref: assert property (p_ref) else $error("run at zero speed");
endmodule
bind eom_top eom_chk u_chk (.CLK(CLK), .RST(RST), .TRIPS_IN(TRIPS_IN),
   .RUN_CMD(RUN_CMD), .REF_VALID(REF_VALID),
   .SAFE_TORQUE_OFF_N(SAFE_TORQUE_OFF_N), .OVERRIDE_ACTIVE(OVERRIDE_ACTIVE),
   .RUN_OUT(RUN_OUT), .SPEED_OUT(SPEED_OUT), .TRIP_OUT(TRIP_OUT),
   .TRIPS_OUT(TRIPS_OUT));

// ---- verification/eom_fire_panel.sv ----
module eom_fire_panel (
   input  wire logic       alarm,
   input  wire logic       nc,
   input  wire logic [2:0] pos,
   output logic      [7:0] din
);
   timeunit 1ns;
   timeprecision 1ns;
   // other inputs show the inverse so a wrong index is seen
   always_comb begin
      din = {8{~(alarm ^ nc)}};
      din[pos] = alarm ^ nc;
   end
endmodule

// ---- verification/emergency_override_mode_control_tb.sv ----
module emergency_override_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [15:0] c; logic [2:0] p; logic a;
      logic [1:0] s;} eom_row_t;
   eom_row_t rows [7] = '{'{16'h0004,3'h1,1'b1,2'h3}, '{16'h0028,3'h1,1'b1,2'h3},
      '{16'h002D,3'h1,1'b0,2'h1}, '{16'h0005,3'h1,1'b1,2'h0},
      '{16'h0300,3'h3,1'b1,2'h3}, '{16'h0300,3'h1,1'b1,2'h1},
      '{16'h0004,3'h2,1'b1,2'h1}};
   logic CLK = 0, RST = 1, WR = 0, RD = 0, RUN_CMD = 0, REF_VALID = 0;
   logic SAFE_TORQUE_OFF_N = 1, alarm = 0, nc = 0;
   logic OVERRIDE_ACTIVE, RUN_OUT, TRIP_OUT, IRQ;
   logic [2:0]  pos = 3'h1;
   logic [3:0]  ADDR = 4'h0;
   logic [7:0]  DIN;
   logic [13:0] TRIPS_IN = 14'h0000, TRIPS_OUT;
   logic [15:0] WDATA = 16'h0000, REF_SPEED = 16'h0000, RDATA, SPEED_OUT, d;
   int bad_count = 0, tests_run = 0, n;
   always #20 CLK = ~CLK;
   eom_fire_panel u_fire (.alarm(alarm), .nc(nc), .pos(pos), .din(DIN));
   eom_top uut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .DIN(DIN), .TRIPS_IN(TRIPS_IN),
      .RUN_CMD(RUN_CMD), .REF_VALID(REF_VALID), .REF_SPEED(REF_SPEED),
      .SAFE_TORQUE_OFF_N(SAFE_TORQUE_OFF_N), .OVERRIDE_ACTIVE(OVERRIDE_ACTIVE),
      .RUN_OUT(RUN_OUT), .SPEED_OUT(SPEED_OUT), .TRIP_OUT(TRIP_OUT),
      .TRIPS_OUT(TRIPS_OUT), .IRQ(IRQ));
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge CLK); ADDR <= a; WDATA <= v; WR <= 1'b1;
      @(posedge CLK); WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge CLK); ADDR <= a; RD <= 1'b1;
      @(posedge CLK); RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge CLK);
   endtask
   task automatic give_verdict();
      $display("mismatches %0d of %0d checks", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge CLK); RST <= 1'b0;
      wr(4'h4, 16'h0007);
      foreach (rows[i]) begin
         wr(4'h0, rows[i].c); pos <= rows[i].p; nc <= rows[i].c[5];
         alarm <= rows[i].a; settle(); rd(4'h2);
         chk(d, {14'h0, rows[i].s});
      end
      wr(4'h3, 16'h0007); settle(); chk(IRQ, 0);
      pos <= 3'h1; settle(); chk(IRQ, 1); rd(4'h3); chk(d, 16'h0001);
      // ---------------------------------------------------------------
      // override speed zero, then nonzero
      // ---------------------------------------------------------------
      RUN_CMD <= 1; REF_VALID <= 1; REF_SPEED <= 16'h0123; settle();
      chk({RUN_OUT, SPEED_OUT[14:0]}, 16'h8123);
      RUN_CMD <= 0; settle(); chk(RUN_OUT, 0);
      wr(4'h1, 16'h0456); REF_VALID <= 0; RUN_CMD <= 1; settle();
      chk(SPEED_OUT, 16'h0456); chk(RUN_OUT, 1);
      SAFE_TORQUE_OFF_N <= 0; settle(); chk(RUN_OUT, 0);
      SAFE_TORQUE_OFF_N <= 1; TRIPS_IN <= 14'h01FF; settle();
      chk({TRIP_OUT, TRIPS_OUT}, 0); chk(RUN_OUT, 1);
      // ---------------------------------------------------------------
      // hard fault: trip, then restart after the wait
      // ---------------------------------------------------------------
      TRIPS_IN <= 14'h0200; settle(); chk(TRIP_OUT, 1);
      TRIPS_IN <= 14'h0000; n = 0;
      while (RUN_OUT !== 1'b1 && n < 4000) begin @(posedge CLK); n++; end
      if (n >= 4000) begin bad_count++; give_verdict(); end
      chk(n >= 2490, 1); rd(4'h3); chk(d[2], 1);
      alarm <= 0; RUN_CMD <= 0; settle(); chk(OVERRIDE_ACTIVE, 0);
      TRIPS_IN <= 14'h0001; settle(); chk(TRIP_OUT, 1);
      chk(TRIPS_OUT, 14'h0001); rd(4'h3); chk(d[1], 1);
      wr(4'h4, 16'h0000); wr(4'h3, 16'h0007); TRIPS_IN <= 14'h0000;
      alarm <= 1; settle(); chk(IRQ, 0); rd(4'hF); chk(d, 0);
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge CLK);
      bad_count++;
      give_verdict();
   end
endmodule
